// ---- lsg_far.sv ----
// Pin-side circuitry model: board drivers, pullups, LCD and SPI sources
`timescale 1ns/1ns
`default_nettype none
module lsg_far
(
  // From the block
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [7:0] pb_out,
  input wire logic [7:0] pb_oe,
  input wire logic [7:0] pb_pullup_en,
  input wire logic [7:0] pb_ext,
  input wire logic [3:0] pc_out,
  input wire logic [3:0] pc_oe,
  input wire logic [3:0] pc_pullup_en,
  input wire logic [3:0] pc_ext,
  // To the block
  output logic [7:0]     pb_in,
  output logic [3:0]     pc_in,
  output logic [7:0]     lcd_frontplane,
  output logic           spi_sck_out,
  output logic           spi_sdo_out
);
  logic [7:0] cnt_q;
  // ****************
  // Wire levels
  // ****************
  always @(posedge clock or posedge rst)
    if (rst)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_q + 8'h01;
  // Undriven pin: pullup wins, else the board drive
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & (pb_pullup_en | pb_ext));
  assign pc_in = (pc_oe & pc_out) | (~pc_oe & (pc_pullup_en | pc_ext));
  assign lcd_frontplane = cnt_q;
  assign spi_sck_out = cnt_q[0];
  assign spi_sdo_out = cnt_q[1];
endmodule
`default_nettype wire

// ---- lsg_map.vh ----
// Register map and field constants for the shared LCD/SPI port block
`ifndef LSG_MAP_VH
`define LSG_MAP_VH
// Register indices; byte address is four times the index
`define LSG_IDX_PB_DATA        4'h1
`define LSG_IDX_PC_DATA        4'h2
`define LSG_IDX_PB_DIR         4'h1
`define LSG_IDX_PC_DIR         4'h2
`define LSG_IDX_PULLUP         4'h9
`define LSG_IDX_PULLUP_SECOND  4'hB
`define LSG_IDX_OPEN_DRAIN     4'hA
`define LSG_IDX_LCD_CONTROL    4'hC
`define LSG_IDX_SPI_CONTROL    4'hD
// Field positions
`define LSG_PB_LOW_PULLUP      0
`define LSG_PB_HIGH_PULLUP     1
`define LSG_PC_PULLUP          0
`define LSG_PB_LOW_OPEN_DRAIN  0
`define LSG_PB_HIGH_OPEN_DRAIN 1
`define LSG_PC_OPEN_DRAIN      2
`define LSG_PB_LOW_PORT_ENABLE 0
`define LSG_PB_HIGH_PORT_ENABLE 1
`define LSG_SPI_ENABLE         0
`define LSG_SPI_MASTER         1
// Reset values
`define LSG_RST_ZERO           8'h00
`define LSG_RST_LCD_CONTROL    8'h00
`endif

// ---- lsg_ports.v ----
// Port B and port C pin control with Avalon-MM register slave
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "lsg_map.vh"
//
// How it works
// [RL1] Port B direction bit: 0 input, 1 output
// [RL2] Port B direction at option index 1
// [RL3] Port B direction cleared at reset
// [RL4] Port B pullups per nibble, cleared at reset
// [RL5] Port B open drain per nibble, reset off
// [RL6] Low nibble: LCD, input or output mode
// [RL7] High nibble uses high-half controls likewise
// [RL8] LCD pin reads 0, write stores latch
// [RL9] Output reads latch; input reads pin
// [RL10] Software avoids pullups on LCD nibbles
// [RL11] Port C is four pins shared
// [RL12] Port C data, pullup, open-drain decode
// [RL13] Pullup and open-drain registers reset cleared
// [RL14] SPI enable reassigns port C 0-2
// [RL15] Master select makes serial clock output
// [RL16] Port C read returns pin level
// [RL17] Pin 3 readable regardless of interrupt
// [RL18] Port C pins 2,3 open drain only
// [RL19] Port C direction at option index 2
// [RL20] Single port C pullup bit, reset off
// [RL21] Port C data latch kept over reset
// [RL22] Port B latch kept; LCD enabled reset
// [RL23] Open-drain bit applies pins 0,1
// [RL24] Option select routes shared addresses
module lsg_ports
(
  // System
  input  wire        clock,
  input  wire        rst,
  // Avalon-MM slave
  input  wire [5:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  output reg  [1:0]  response,
  // Option map select
  input  wire        option_map,
  // Port B pins
  input  wire [7:0]  pb_in,
  output reg  [7:0]  pb_out,
  output reg  [7:0]  pb_oe,
  output reg  [7:0]  pb_pullup_en,
  output reg  [7:0]  pb_lcd_sel,
  // LCD frontplane source
  input  wire [7:0]  lcd_frontplane,
  // Port C pins
  input  wire [3:0]  pc_in,
  output reg  [3:0]  pc_out,
  output reg  [3:0]  pc_oe,
  output reg  [3:0]  pc_pullup_en,
  // SPI side
  input  wire        spi_sck_out,
  input  wire        spi_sdo_out,
  output reg         spi_sck_in,
  output reg         spi_sdi_in,
  output reg         spi_enable,
  output reg         spi_master,
  output reg         irq_level
);

  // ****************************************************
  // Registers
  // ****************************************************
  reg  [7:0] pb_latch_q;
  reg  [7:0] pb_dir_q;
  reg  [3:0] pc_latch_q;
  reg  [3:0] pc_dir_q;
  reg  [7:0] pullup_q;
  reg  [7:0] pullup_second_q;
  reg  [7:0] open_drain_q;
  reg  [7:0] lcd_control_q;
  reg  [7:0] spi_control_q;
  reg  [7:0] pb_sync1_q;
  reg  [7:0] pb_sync2_q;
  reg  [3:0] pc_sync1_q;
  reg  [3:0] pc_sync2_q;
  reg        opt_sync1_q;
  reg        opt_sync2_q;
  reg        ack_q;

  wire [3:0] idx;
  wire       req;
  wire       mapped;
  wire [7:0] pb_read;
  wire [3:0] pc_read;
  assign idx = address[5:2];
  assign req = (read | write) & ~ack_q;

  // Option-map decode, shared by read and write paths
  function dec;
    input [3:0] i;
    input       opt;
    begin
      dec = 1'b0;
      if (opt) // RL24
      begin
        if (i == `LSG_IDX_PB_DIR || i == `LSG_IDX_PC_DIR || i == `LSG_IDX_PULLUP ||
            i == `LSG_IDX_PULLUP_SECOND || i == `LSG_IDX_OPEN_DRAIN ||
            i == `LSG_IDX_LCD_CONTROL || i == `LSG_IDX_SPI_CONTROL)
          dec = 1'b1;
      end
      else if (i == `LSG_IDX_PB_DATA || i == `LSG_IDX_PC_DATA) // RL12
        dec = 1'b1;
    end
  endfunction

  assign mapped = dec(idx, opt_sync2_q);

  // ****************************************************
  // Pin input synchronisers
  // ****************************************************
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pb_sync1_q  <= 8'h00;
      pb_sync2_q  <= 8'h00;
      pc_sync1_q  <= 4'h0;
      pc_sync2_q  <= 4'h0;
      opt_sync1_q <= 1'b0;
      opt_sync2_q <= 1'b0;
    end
    else
    begin
      pb_sync1_q  <= pb_in;
      pb_sync2_q  <= pb_sync1_q;
      pc_sync1_q  <= pc_in;
      pc_sync2_q  <= pc_sync1_q;
      opt_sync1_q <= option_map;
      opt_sync2_q <= opt_sync1_q;
    end
  end

  // ****************************************************
  // Data readback
  // ****************************************************
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : pb_rd
      wire pe;
      assign pe = (g < 4) ? lcd_control_q[`LSG_PB_LOW_PORT_ENABLE]
                          : lcd_control_q[`LSG_PB_HIGH_PORT_ENABLE];
      assign pb_read[g] = !pe ? 1'b0 :                      // RL8
                          pb_dir_q[g] ? pb_latch_q[g] :     // RL9
                          pb_sync2_q[g];
    end
  endgenerate
  assign pc_read = pc_sync2_q; // RL16 RL17

  // ****************************************************
  // Avalon slave: one wait cycle, then ack
  // ****************************************************
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ack_q       <= 1'b0;
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
      response    <= 2'b00;
    end
    else
    begin
      ack_q       <= req;
      waitrequest <= ~req;
      if (req)
      begin
        response <= mapped ? 2'b00 : 2'b11;
        readdata <= 32'h0000_0000;
        if (read && mapped)
        begin
          if (opt_sync2_q)
          begin
            case (idx)
              `LSG_IDX_PB_DIR:        readdata <= {24'h00_0000, pb_dir_q};
              `LSG_IDX_PC_DIR:        readdata <= {28'h000_0000, pc_dir_q};
              `LSG_IDX_PULLUP:        readdata <= {24'h00_0000, pullup_q};
              `LSG_IDX_PULLUP_SECOND: readdata <= {24'h00_0000, pullup_second_q};
              `LSG_IDX_OPEN_DRAIN:    readdata <= {24'h00_0000, open_drain_q};
              `LSG_IDX_LCD_CONTROL:   readdata <= {24'h00_0000, lcd_control_q};
              default:                readdata <= {24'h00_0000, spi_control_q};
            endcase
          end
          else if (idx == `LSG_IDX_PB_DATA)
            readdata <= {24'h00_0000, pb_read};
          else
            readdata <= {28'h000_0000, pc_read};
        end
      end
    end
  end

  // Control registers: reset cleared, LCD drivers enabled
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pb_dir_q        <= `LSG_RST_ZERO;        // RL3
      pc_dir_q        <= 4'h0;                 // RL19
      pullup_q        <= `LSG_RST_ZERO;        // RL4 RL13
      pullup_second_q <= `LSG_RST_ZERO;        // RL20
      open_drain_q    <= `LSG_RST_ZERO;        // RL5 RL13
      lcd_control_q   <= `LSG_RST_LCD_CONTROL; // RL22
      spi_control_q   <= `LSG_RST_ZERO;
    end
    else if (req && write && mapped && opt_sync2_q)
    begin
      case (idx)
        `LSG_IDX_PB_DIR:        pb_dir_q <= writedata[7:0];        // RL2
        `LSG_IDX_PC_DIR:        pc_dir_q <= writedata[3:0];        // RL19
        `LSG_IDX_PULLUP:        pullup_q <= writedata[7:0];        // RL12
        `LSG_IDX_PULLUP_SECOND: pullup_second_q <= writedata[7:0];
        `LSG_IDX_OPEN_DRAIN:    open_drain_q <= writedata[7:0];    // RL12
        `LSG_IDX_LCD_CONTROL:   lcd_control_q <= writedata[7:0];
        default:                spi_control_q <= writedata[7:0];
      endcase
    end
  end

  // Data latches are not reset
  always @(posedge clock)
  begin
    if (req && write && mapped && !opt_sync2_q)
    begin
      if (idx == `LSG_IDX_PB_DATA)
        pb_latch_q <= writedata[7:0]; // RL8 RL9 RL22
      else
        pc_latch_q <= writedata[3:0]; // RL21
    end
  end

  // ****************************************************
  // Pin drivers
  // ****************************************************
  wire [7:0] pb_out_d;
  wire [7:0] pb_oe_d;
  wire [7:0] pb_pu_d;
  wire [7:0] pb_lcd_d;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : pb_pin
      wire pe;
      wire od;
      wire pu;
      assign pe = (g < 4) ? lcd_control_q[`LSG_PB_LOW_PORT_ENABLE]      // RL6
                          : lcd_control_q[`LSG_PB_HIGH_PORT_ENABLE];    // RL7
      assign od = (g < 4) ? open_drain_q[`LSG_PB_LOW_OPEN_DRAIN]
                          : open_drain_q[`LSG_PB_HIGH_OPEN_DRAIN];      // RL5
      assign pu = (g < 4) ? pullup_q[`LSG_PB_LOW_PULLUP]
                          : pullup_q[`LSG_PB_HIGH_PULLUP];              // RL4
      assign pb_lcd_d[g] = ~pe;
      assign pb_out_d[g] = pe ? pb_latch_q[g] : lcd_frontplane[g];
      assign pb_oe_d[g]  = ~pe | (pb_dir_q[g] & (~od | ~pb_latch_q[g])); // RL1 RL6
      // Pullup is dropped whenever the port drives the pin in port mode; LCD pins keep it
      assign pb_pu_d[g]  = pu & ~(pe & pb_oe_d[g]);                    // RL4
    end
  endgenerate

  reg [3:0] pc_out_d;
  reg [3:0] pc_oe_d;
  reg       pc_od;
  always @*
  begin
    pc_od    = open_drain_q[`LSG_PC_OPEN_DRAIN];
    pc_out_d = pc_latch_q;
    pc_oe_d  = pc_dir_q;                                       // RL11
    if (spi_control_q[`LSG_SPI_ENABLE])                        // RL14
    begin
      pc_out_d[0] = spi_sck_out;
      pc_oe_d[0]  = spi_control_q[`LSG_SPI_MASTER];            // RL15
      pc_out_d[1] = spi_sdo_out;
      pc_oe_d[1]  = 1'b1;
      pc_oe_d[2]  = 1'b0;
    end
    if (pc_od)                                                 // RL23
    begin
      pc_oe_d[0] = pc_oe_d[0] & ~pc_out_d[0];
      pc_oe_d[1] = pc_oe_d[1] & ~pc_out_d[1];
    end
    pc_oe_d[2]  = pc_oe_d[2] & ~pc_out_d[2];                   // RL18
    pc_oe_d[3]  = pc_oe_d[3] & ~pc_out_d[3];                   // RL18
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pb_out       <= 8'h00;
      pb_oe        <= 8'h00;
      pb_pullup_en <= 8'h00;
      pb_lcd_sel   <= 8'h00;
      pc_out       <= 4'h0;
      pc_oe        <= 4'h0;
      pc_pullup_en <= 4'h0;
      spi_sck_in   <= 1'b0;
      spi_sdi_in   <= 1'b0;
      spi_enable   <= 1'b0;
      spi_master   <= 1'b0;
      irq_level    <= 1'b0;
    end
    else
    begin
      pb_out       <= pb_out_d;
      pb_oe        <= pb_oe_d;
      pb_pullup_en <= pb_pu_d;
      pb_lcd_sel   <= pb_lcd_d;
      pc_out       <= pc_out_d;
      pc_oe        <= pc_oe_d;
      pc_pullup_en <= {4{pullup_second_q[`LSG_PC_PULLUP]}} & ~pc_oe_d; // RL20
      spi_sck_in   <= pc_sync2_q[0];
      spi_sdi_in   <= pc_sync2_q[2];
      spi_enable   <= spi_control_q[`LSG_SPI_ENABLE];
      spi_master   <= spi_control_q[`LSG_SPI_MASTER];
      irq_level    <= pc_sync2_q[3];                           // RL17
    end
  end

endmodule
`default_nettype wire

// ---- lsg_ports_monitor.sv ----
// Concurrent checks on the shared LCD/SPI port block
`timescale 1ns/1ns
`default_nettype none
module lsg_ports_monitor
(
  // System and bus
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic [1:0]  response,
  // Pins
  input wire logic [7:0]  pb_oe,
  input wire logic [7:0]  pb_pullup_en,
  input wire logic [7:0]  pb_lcd_sel,
  input wire logic [3:0]  pc_in,
  input wire logic [3:0]  pc_out,
  input wire logic [3:0]  pc_oe,
  input wire logic        spi_sck_in,
  input wire logic        spi_sdi_in,
  input wire logic        spi_enable,
  input wire logic        spi_master,
  input wire logic        irq_level
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ****************
  // Properties
  // ****************
  property p_answer; $rose(read || write) |=> !waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("late bus answer");
  property p_decerr; !waitrequest && response == 2'b11 |-> readdata == 32'h0000_0000; endproperty
  a_decerr: assert property (p_decerr) else $error("refused read not zero");
  property p_rst_lcd; $fell(rst) |=> pb_lcd_sel == 8'hFF && pb_oe == 8'hFF; endproperty
  a_rst_lcd: assert property (p_rst_lcd) else $error("LCD not on after reset");
  property p_lcd_oe; (pb_oe | ~pb_lcd_sel) == 8'hFF; endproperty
  a_lcd_oe: assert property (p_lcd_oe) else $error("LCD pin not driven");
  property p_pc_od; (pc_oe[3:2] & pc_out[3:2]) == 2'b00; endproperty
  a_pc_od: assert property (p_pc_od) else $error("pin 2/3 drives high");
  property p_pb_pull; (pb_pullup_en & pb_oe & ~pb_lcd_sel) == 8'h00; endproperty
  a_pb_pull: assert property (p_pb_pull) else $error("pullup on driven pin");
  property p_sync;
    $stable(pc_in)[*4] |-> {irq_level, spi_sdi_in, spi_sck_in} == {pc_in[3:2], pc_in[0]};
  endproperty
  a_sync: assert property (p_sync) else $error("pin level not followed");
  property p_spi; spi_enable |-> !pc_oe[2] && (spi_master || !pc_oe[0]); endproperty
  a_spi: assert property (p_spi) else $error("SPI input pin driven");
endmodule
bind lsg_ports lsg_ports_monitor mon_u (.clock, .rst, .read, .write, .readdata, .waitrequest,
  .response, .pb_oe, .pb_pullup_en, .pb_lcd_sel, .pc_in, .pc_out, .pc_oe, .spi_sck_in,
  .spi_sdi_in, .spi_enable, .spi_master, .irq_level);
`default_nettype wire

// ---- testbench.sv ----
// Directed register and pin test of the shared port block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clock = 0, rst = 1, read = 0, write = 0, option_map = 0, waitrequest;
  logic spi_sck_out, spi_sdo_out, spi_sck_in, spi_sdi_in, spi_enable, spi_master, irq_level;
  logic [5:0] address = 6'h00;
  logic [31:0] writedata = 32'h0000_0000, readdata, rd;
  logic [1:0] response, rs;
  logic [7:0] pb_in, pb_out, pb_oe, pb_pullup_en, pb_lcd_sel, lcd_frontplane, pb_ext = 8'h3C;
  logic [3:0] pc_in, pc_out, pc_oe, pc_pullup_en, pc_ext = 4'h0;
  logic [3:0] zero_idx [5] = '{4'h1, 4'h2, 4'h9, 4'hA, 4'hB};
  int error_cnt = 0, comparisons = 0;
  lsg_ports dut_u (.clock, .rst, .address, .read, .write, .writedata, .readdata, .waitrequest,
    .response, .option_map, .pb_in, .pb_out, .pb_oe, .pb_pullup_en, .pb_lcd_sel,
    .lcd_frontplane, .pc_in, .pc_out, .pc_oe, .pc_pullup_en, .spi_sck_out, .spi_sdo_out,
    .spi_sck_in, .spi_sdi_in, .spi_enable, .spi_master, .irq_level);
  lsg_far far_u (.clock, .rst, .pb_out, .pb_oe, .pb_pullup_en, .pb_ext, .pc_out, .pc_oe,
    .pc_pullup_en, .pc_ext, .pb_in, .pc_in, .lcd_frontplane, .spi_sck_out, .spi_sdo_out);
  always #4 clock = ~clock;
  // ****************
  // Tasks
  // ****************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    address <= {idx, 2'b00};
    read <= !w;
    write <= w;
    writedata <= {24'h00_0000, d};
    do
    begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      error_cnt++;
    rd = readdata;
    rs = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task rdchk(input string nm, input logic [3:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(nm, rd, exp);
  endtask
  task opt(input logic v);
    @(posedge clock);
    option_map <= v;
    repeat (3) @(posedge clock);
  endtask
  task settle;
    repeat (3) @(posedge clock);
  endtask
  task do_reset;
    @(posedge clock);
    rst <= 1'b1;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    settle;
    chk("pb_lcd_sel", pb_lcd_sel, 8'hFF);
  endtask
  task wrap_up;
    if (error_cnt == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ****************
  // Tests
  // ****************
  initial
  begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    wrap_up;
  end
  initial
  begin
    do_reset;
    chk("pb_oe", pb_oe, 8'hFF);
    bus(1'b1, 4'h1, 8'hA5);
    rdchk("pb lcd read", 4'h1, 32'h0000_0000);
    opt(1'b1);
    for (int i = 0; i < 5; i++)
      rdchk("reset value", zero_idx[i], 32'h0000_0000);
    rdchk("unmapped", 4'hF, 32'h0000_0000);
    chk("unmapped resp", rs, 2'b11);
    bus(1'b1, 4'hC, 8'h03);
    bus(1'b1, 4'h1, 8'h0F);
    opt(1'b0);
    settle;
    rdchk("pb read", 4'h1, 32'h0000_0035);
    chk("pb_oe", pb_oe, 8'h0F);
    chk("pb_out", pb_out[3:0], 4'h5);
    opt(1'b1);
    bus(1'b1, 4'hA, 8'h01);
    bus(1'b1, 4'h9, 8'h01);
    settle;
    chk("pb_oe od", pb_oe, 8'h0A);
    chk("pb_pullup_en", pb_pullup_en, 8'h05);
    bus(1'b1, 4'h2, 8'h0F);
    opt(1'b0);
    bus(1'b1, 4'h2, 8'h0A);
    settle;
    rdchk("pc read", 4'h2, 32'h0000_0002);
    chk("pc_oe", pc_oe, 4'h7);
    opt(1'b1);
    bus(1'b1, 4'hA, 8'h04);
    settle;
    chk("pc_oe od", pc_oe, 4'h5);
    bus(1'b1, 4'hB, 8'h01);
    bus(1'b1, 4'hD, 8'h01);
    settle;
    chk("pc_oe spi", pc_oe & 4'hD, 4'h0);
    chk("pc_pullup_en", pc_pullup_en[2], 1'b1);
    do_reset;
    rdchk("pc dir", 4'h2, 32'h0000_0000);
    wrap_up;
  end
endmodule
`default_nettype wire
